//--- pulse_width_reload_and_start_gate.sv
// Purpose: Reload registers, pairing modes and start selection for four pulse channels
// Assumes: APB slave, zero wait states, one clock, gate inputs from another block
// Notes:   Odd channels of joined modes stay idle and low
`timescale 1ns/1ps
`default_nettype none

module pulse_width_reload_and_start_gate
	import pulse_gen_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              clk_en,
	input  wire logic              reset_n,
	input  wire apb_req_t          apb_req,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic [NUM_PAIR-1:0] gate_in,
	output logic [NUM_CH-1:0]      pulse_out
);

	// Reload bytes carry no reset on purpose
	logic [7:0]          hi_q [NUM_CH];
	logic [7:0]          lo_q [NUM_CH];
	ch_ctrl_t            ctrl_q [NUM_CH];
	pairing_mode_t       md_q [NUM_PAIR];
	logic [NUM_PAIR-1:0] timing_generator_select_q;
	logic [NUM_PAIR-1:0] trigger_source_select_q;
	logic [NUM_CH-1:0]   pen_q;
	logic [NUM_CH-1:0]   tgo_q;
	logic [PRE_W-1:0]    pre_q;
	logic [NUM_PAIR-1:0] gate_meta_q;
	logic [NUM_PAIR-1:0] gate_s_q;
	logic [31:0]         prdata_q;

	logic [CNT_W-1:0]    hw [NUM_CH];
	logic [CNT_W-1:0]    lw [NUM_CH];
	logic [NUM_CH-1:0]   tk;
	logic [NUM_CH-1:0]   rn;
	logic [NUM_CH-1:0]   own_start;
	logic [NUM_CH-1:0]   pcs_tick;
	logic [NUM_CH-1:0]   uf;
	logic [NUM_CH-1:0]   he;
	logic [NUM_CH-1:0]   flag_set;
	logic [NUM_CH-1:0]   cnt_out;
	logic [NUM_CH-1:0]   idle_odd;

	logic        access;
	logic        wr;
	logic        setup;
	logic        hit;
	logic [31:0] rdata;
	logic [31:0] wd;
	logic [ADDR_W-1:0] addr;

	assign addr   = apb_req.paddr;
	assign wd     = apb_req.pwdata;
	assign setup  = apb_req.psel & ~apb_req.penable & clk_en;
	assign access = apb_req.psel & apb_req.penable & clk_en;
	assign wr     = access & apb_req.pwrite;
	assign pready = access;
	assign pslverr = access & ~hit;
	assign prdata = prdata_q;

	// Gate comes from another block; two stages before use
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			gate_meta_q <= '0;
			gate_s_q    <= '0;
		end else if (clk_en) begin
			gate_meta_q <= gate_in;
			gate_s_q    <= gate_meta_q;
		end
	end

	// Shared free-running prescaler for the divided count clock choices
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pre_q <= '0;
		end else if (clk_en) begin
			pre_q <= pre_q + 1'b1;
		end
	end

	// Pair level control: mode, start select, gate select
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			for (int p = 0; p < NUM_PAIR; p++) begin
				md_q[p] <= MODE_8;
			end
			timing_generator_select_q <= '0;
			trigger_source_select_q <= GATE_RESET[GATE_TRIGGER_SOURCE_SELECT_LO+1:GATE_TRIGGER_SOURCE_SELECT_LO];
		end else if (wr) begin
			for (int p = 0; p < NUM_PAIR; p++) begin
				if (addr == CTRL_BASE + ADDR_W'(4 * p)) begin
					md_q[p]   <= pairing_mode_t'(wd[CE_MD+1:CE_MD]); // [R19]
					timing_generator_select_q[p] <= wd[CE_TIMING_GENERATOR_SELECT]; // [R20]
				end
			end
			if (addr == GATE_OFS) begin
				trigger_source_select_q[0] <= wd[GATE_TRIGGER_SOURCE_SELECT_LO]; // [R10]
				trigger_source_select_q[1] <= wd[GATE_TRIGGER_SOURCE_SELECT_HI]; // [R10]
			end
		end
	end

	// Start and timing generator enables, one bit per channel
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pen_q <= '0;
			tgo_q <= '0;
		end else if (wr) begin
			if (addr == START_OFS) begin
				pen_q <= wd[NUM_CH-1:0]; // [R16]
			end
			if (addr == TG_OFS) begin
				tgo_q <= wd[NUM_CH-1:0]; // [R14]
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			localparam int P = g / 2;
			localparam logic ODD = (g % 2) == 1;
			localparam int PUF_B  = ODD ? CO_PUF : CE_PUF;
			localparam int INTM_B = ODD ? CO_INTM : CE_INTM;
			localparam int PCS_B  = ODD ? CO_PCS : CE_PCS;

			// Reload bytes update any time, even while running
			always_ff @(posedge clk) begin
				if (clk_en && wr && addr == RELOAD_BASE + ADDR_W'(4 * g)) begin
					hi_q[g] <= wd[RL_HI+7:RL_HI]; // [R2] [R7] [R8]
					lo_q[g] <= wd[7:0]; // [R2] [R8]
				end
			end

			// Per channel control; hardware set beats software clear
			always_ff @(posedge clk) begin
				if (!reset_n) begin
					ctrl_q[g] <= '{underflow_flag: 1'b0, intm: 1'b0, pcs: PCS_RESET};
				end else if (clk_en) begin
					if (wr && addr == CTRL_BASE + ADDR_W'(4 * P)) begin
						ctrl_q[g].intm <= wd[INTM_B];
						ctrl_q[g].pcs  <= wd[PCS_B+1:PCS_B];
						ctrl_q[g].underflow_flag <= flag_set[g] |
							(ctrl_q[g].underflow_flag & wd[PUF_B]); // [R21]
					end else if (flag_set[g]) begin
						ctrl_q[g].underflow_flag <= 1'b1; // [R21]
					end
				end
			end

			always_comb begin
				case (ctrl_q[g].pcs)
					2'h0:    pcs_tick[g] = 1'b1;
					2'h1:    pcs_tick[g] = (pre_q & PRE_MASK4) == '0;
					2'h2:    pcs_tick[g] = (pre_q & PRE_MASK16) == '0;
					default: pcs_tick[g] = (pre_q & PRE_MASK64) == '0;
				endcase
			end

			// Start source: timing generator, gate or start register
			assign own_start[g] = timing_generator_select_q[P] ? tgo_q[g] : // [R14] [R20]
				trigger_source_select_q[P] ? gate_s_q[P] : pen_q[g]; // [R9] [R15] [R16]

			pulse_counter u_cnt (
				.clk        (clk),
				.clk_en     (clk_en),
				.reset_n    (reset_n),
				.run        (rn[g]),
				.tick       (tk[g]),
				.high_width (hw[g]),
				.low_width  (lw[g]),
				.pulse_out  (cnt_out[g]),
				.underflow  (uf[g]),
				.high_end   (he[g])
			);

			// Joined odd channels report the even channel's events
			always_comb begin
				if (idle_odd[g]) begin
					flag_set[g] = ctrl_q[g].intm ? he[g ^ 1] : uf[g ^ 1];
				end else begin
					flag_set[g] = ctrl_q[g].intm ? he[g] : uf[g];
				end
			end
		end
	endgenerate

	// Pairing of reload values, count clocks and starts
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			hw[c] = {8'h00, hi_q[c]}; // [R3]
			lw[c] = {8'h00, lo_q[c]}; // [R3]
			tk[c] = pcs_tick[c];
			rn[c] = own_start[c];
			idle_odd[c] = 1'b0;
			case (md_q[c / 2])
				MODE_8_8: begin
					if (c % 2 == 0) begin
						tk[c] = uf[c ^ 1]; // [R4]
						rn[c] = own_start[c];
					end else begin
						rn[c] = own_start[c ^ 1]; // [R4]
					end
				end
				MODE_16: begin
					if (c % 2 == 0) begin
						hw[c] = {hi_q[c], lo_q[c]}; // [R5]
						lw[c] = {hi_q[c ^ 1], lo_q[c ^ 1]}; // [R5]
					end else begin
						rn[c] = 1'b0;
						idle_odd[c] = 1'b1;
					end
				end
				MODE_16_16: begin
					if (c % 2 == 0) begin
						hw[c] = {hi_q[c], lo_q[c]}; // [R6]
						lw[c] = {hi_q[c ^ 1], lo_q[c ^ 1]}; // [R6]
						if ((c / 2) % 2 == 0) begin
							tk[c] = uf[c ^ 2]; // [R6]
						end else begin
							rn[c] = own_start[c ^ 2]; // [R6]
						end
					end else begin
						rn[c] = 1'b0;
						idle_odd[c] = 1'b1;
					end
				end
				default: begin
					hw[c] = {8'h00, hi_q[c]};
				end
			endcase
		end
	end

	// Prescaler sides are internal; their outputs stay low
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			pulse_out[c] = cnt_out[c];
			if (md_q[c / 2] == MODE_8_8 && c % 2 == 1) begin
				pulse_out[c] = 1'b0;
			end
			if (md_q[c / 2] == MODE_16_16 && (c / 2) % 2 == 1) begin
				pulse_out[c] = 1'b0;
			end
		end
	end

	// Read mux and decode
	always_comb begin
		rdata = '0;
		hit   = 1'b0;
		for (int c = 0; c < NUM_CH; c++) begin
			if (addr == RELOAD_BASE + ADDR_W'(4 * c)) begin
				rdata = {16'h0000, hi_q[c], lo_q[c]}; // [R8]
				hit   = 1'b1;
			end
		end
		for (int p = 0; p < NUM_PAIR; p++) begin
			if (addr == CTRL_BASE + ADDR_W'(4 * p)) begin
				rdata[CE_PUF]             = ctrl_q[2 * p].underflow_flag;
				rdata[CE_INTM]            = ctrl_q[2 * p].intm;
				rdata[CE_PCS+1:CE_PCS]    = ctrl_q[2 * p].pcs;
				rdata[CE_MD+1:CE_MD]      = md_q[p];
				rdata[CE_TIMING_GENERATOR_SELECT]            = timing_generator_select_q[p];
				rdata[CO_PUF]             = ctrl_q[2 * p + 1].underflow_flag;
				rdata[CO_INTM]            = ctrl_q[2 * p + 1].intm;
				rdata[CO_PCS+1:CO_PCS]    = ctrl_q[2 * p + 1].pcs;
				hit = 1'b1;
			end
		end
		if (addr == GATE_OFS) begin
			// Level select and reserved bits always read zero
			rdata[GATE_TRIGGER_SOURCE_SELECT_LO] = trigger_source_select_q[0]; // [R10] [R11] [R12]
			rdata[GATE_TRIGGER_SOURCE_SELECT_HI] = trigger_source_select_q[1]; // [R10] [R11] [R12]
			hit = 1'b1;
		end
		if (addr == START_OFS) begin
			rdata[NUM_CH-1:0] = pen_q;
			hit = 1'b1;
		end
		if (addr == TG_OFS) begin
			rdata[NUM_CH-1:0] = tgo_q;
			hit = 1'b1;
		end
		if (addr == STATUS_OFS) begin
			rdata[NUM_CH-1:0]        = cnt_out;
			rdata[2*NUM_CH-1:NUM_CH] = rn;
			hit = 1'b1;
		end
	end

	// Read data captured in setup so it stands through the access phase
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			prdata_q <= '0;
		end else if (setup) begin
			prdata_q <= apb_req.pwrite ? 32'h0000_0000 : rdata;
		end
	end

endmodule : pulse_width_reload_and_start_gate

`default_nettype wire

//--- pulse_gen_pkg.sv
// Purpose: Shared constants and types for the four-channel pulse width reload and start gate
// Assumes: 32-bit APB, one aligned word per register, 125 MHz clock
// Notes:   Overview of operation follows
//
// Overview of operation
// R1: Each phase lasts reload plus one ticks
// R2: Reload values writable while channels run
// R3: 8-bit mode uses own high, low bytes
// R4: 8+8 mode: odd channel prescales even channel
// R5: 16-bit mode joins even and odd registers
// R6: 16+16 mode: second pair prescales first pair
// R7: High width passes through a buffer register
// R8: Reload bytes store any value, reset undefined
// R9: Trigger select picks start register or gate
// R10: Bit 1 governs pair n, bit 5 pair n+2
// R11: Start level bits 0 and 4 read zero
// R12: Reserved gate bits 7:6, 3:2 read zero
// R13: Running channel alternates phases until stopped
// R14: Timing generator start cleared stops channel
// R15: Gate deassertion stops gate-started channel
// R16: Start enable cleared stops register-started channel
// R17: Reset halts every channel
// R18: Software selects pairing mode before starting
// R19: Mode field selects 8, 8+8, 16, 16+16
// R20: Timing generator select picks timing generator start
// R21: Underflow sets flag, software writes 0 clears
// R22: Buffered high width loads at next high phase
// R23: Stop returns output idle and clears counter

package pulse_gen_pkg;

	localparam int NUM_CH   = 4;
	localparam int NUM_PAIR = 2;
	localparam int ADDR_W   = 12;
	localparam int CNT_W    = 16;
	localparam int PRE_W    = 6;

	localparam logic [ADDR_W-1:0] RELOAD_BASE = 12'h000;
	localparam logic [ADDR_W-1:0] CTRL_BASE   = 12'h010;
	localparam logic [ADDR_W-1:0] GATE_OFS    = 12'h018;
	localparam logic [ADDR_W-1:0] START_OFS   = 12'h01c;
	localparam logic [ADDR_W-1:0] TG_OFS      = 12'h020;
	localparam logic [ADDR_W-1:0] STATUS_OFS  = 12'h024;

	localparam int RL_HI    = 8;
	localparam int CE_PUF   = 14;
	localparam int CE_INTM  = 13;
	localparam int CE_PCS   = 11;
	localparam int CE_MD    = 9;
	localparam int CE_TIMING_GENERATOR_SELECT  = 8;
	localparam int CO_PUF   = 6;
	localparam int CO_INTM  = 5;
	localparam int CO_PCS   = 3;
	localparam int GATE_TRIGGER_SOURCE_SELECT_LO = 1;
	localparam int GATE_TRIGGER_SOURCE_SELECT_HI = 5;

	localparam logic [7:0]  GATE_RESET = 8'h00;
	localparam logic [1:0]  PCS_RESET  = 2'h0;
	localparam logic [PRE_W-1:0] PRE_MASK4  = 6'h03;
	localparam logic [PRE_W-1:0] PRE_MASK16 = 6'h0f;
	localparam logic [PRE_W-1:0] PRE_MASK64 = 6'h3f;

	typedef enum logic [1:0] {
		MODE_8     = 2'h0,
		MODE_8_8   = 2'h1,
		MODE_16    = 2'h2,
		MODE_16_16 = 2'h3
	} pairing_mode_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_LOW  = 2'h1,
		ST_HIGH = 2'h3
	} cnt_state_t;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0]       pwdata;
	} apb_req_t;

	typedef struct packed {
		logic       underflow_flag;
		logic       intm;
		logic [1:0] pcs;
	} ch_ctrl_t;

endpackage : pulse_gen_pkg

//--- pulse_counter.sv
// Purpose: One down-counter producing alternating low and high phases
// Assumes: tick is a one-cycle count enable on clk
// Notes:   Output is low while idle
`timescale 1ns/1ps
`default_nettype none

module pulse_counter
	import pulse_gen_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             clk_en,
	input  wire logic             reset_n,
	input  wire logic             run,
	input  wire logic             tick,
	input  wire logic [CNT_W-1:0] high_width,
	input  wire logic [CNT_W-1:0] low_width,
	output logic                  pulse_out,
	output logic                  underflow,
	output logic                  high_end
);

	cnt_state_t       st_q;
	logic [CNT_W-1:0] cnt_q;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st_q  <= ST_IDLE; // [R17]
			cnt_q <= '0;
		end else if (clk_en) begin
			if (!run) begin
				st_q  <= ST_IDLE; // [R14] [R15] [R16] [R23]
				cnt_q <= '0;
			end else begin
				case (st_q)
					ST_IDLE: begin
						st_q  <= ST_LOW;
						cnt_q <= low_width;
					end
					ST_LOW: begin
						if (tick) begin
							if (cnt_q == '0) begin
								// High width sampled only here, never mid-phase
								st_q  <= ST_HIGH; // [R13]
								cnt_q <= high_width; // [R7] [R22]
							end else begin
								cnt_q <= cnt_q - 1'b1; // [R1]
							end
						end
					end
					ST_HIGH: begin
						if (tick) begin
							if (cnt_q == '0) begin
								st_q  <= ST_LOW; // [R13]
								cnt_q <= low_width;
							end else begin
								cnt_q <= cnt_q - 1'b1; // [R1]
							end
						end
					end
					default: begin
						st_q  <= ST_IDLE;
						cnt_q <= '0;
					end
				endcase
			end
		end
	end

	assign pulse_out = (st_q == ST_HIGH);
	assign underflow = clk_en & run & tick & (cnt_q == '0) & (st_q != ST_IDLE); // [R21]
	assign high_end  = underflow & (st_q == ST_HIGH);

endmodule : pulse_counter

`default_nettype wire

//--- pulse_gate_source.sv
// Purpose: Gate source standing in for the multifunction timer
// Assumes: Gate is an active high level per channel pair
// Notes:   Slow mode adds one cycle of gate delay
`timescale 1ns/1ps
`default_nettype none

module pulse_gate_source (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       slow,
	input  wire logic [1:0] gate_req,
	output logic      [1:0] gate_in
);
	logic [1:0] g1_q;

	// Gate held low in reset, as the timer outputs are idle then
	always_ff @(posedge clk) begin
		g1_q    <= reset_n ? gate_req : 2'h0;
		gate_in <= reset_n ? (slow ? g1_q : gate_req) : 2'h0;
	end
endmodule : pulse_gate_source

`default_nettype wire

//--- pulse_width_reload_and_start_gate_properties.sv
// Purpose: Port-level properties of the pulse reload and start gate
// Assumes: Shadows of control state track writes seen on the bus
// Notes:   Width and stop checks on channel 0 and pair 0 only, to keep helper logic small
`timescale 1ns/1ps
`default_nettype none

module pulse_width_reload_and_start_gate_properties
	import pulse_gen_pkg::*;
(
	input wire logic                clk,
	input wire logic                clk_en,
	input wire logic                reset_n,
	input wire apb_req_t            apb_req,
	input wire logic [31:0]         prdata,
	input wire logic                pready,
	input wire logic                pslverr,
	input wire logic [NUM_PAIR-1:0] gate_in,
	input wire logic [NUM_CH-1:0]   pulse_out
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	logic        wr, rd, plain, rlv_q;
	logic [15:0] rl0_q, ctl0_q, cnt_q;
	logic [7:0]  gate_q, hl_q;
	logic [3:0]  start_q, tg_q;

	assign wr    = pready & apb_req.pwrite;
	assign rd    = pready & !apb_req.pwrite;
	assign plain = start_q[0] & !gate_q[1] & (ctl0_q[12:8] == 5'h00);

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ctl0_q  <= 16'h0000;
			gate_q  <= 8'h00;
			start_q <= 4'h0;
			tg_q    <= 4'h0;
			rlv_q   <= 1'b0;
		end else if (wr) begin
			case (apb_req.paddr)
			RELOAD_BASE: begin
				rl0_q <= apb_req.pwdata[15:0];
				rlv_q <= 1'b1;
			end
			CTRL_BASE: ctl0_q <= apb_req.pwdata[15:0];
			GATE_OFS: gate_q <= apb_req.pwdata[7:0];
			START_OFS: start_q <= apb_req.pwdata[3:0];
			TG_OFS: tg_q <= apb_req.pwdata[3:0];
			default: ;
			endcase
		end
	end

	// Frozen cycles are not counted, so clk_en stalls do not skew widths
	always_ff @(posedge clk) begin
		if (!reset_n || !pulse_out[0]) begin
			cnt_q <= 16'h0000;
		end else if (clk_en) begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (pulse_out[0] && cnt_q == 16'h0000) begin
			hl_q <= rl0_q[15:8];
		end
	end

	sequence s_gate_rd;
		rd && apb_req.paddr == GATE_OFS;
	endsequence

	sequence s_high_end;
		$fell(pulse_out[0]) && plain;
	endsequence

	chk_reset_idle: assert property (disable iff (1'b0) !reset_n |=> pulse_out == 4'h0)
		else $error("outputs not idle after reset");
	chk_gate_resv: assert property (s_gate_rd |-> prdata[7:6] == 2'h0 && prdata[3:2] == 2'h0)
		else $error("reserved gate bits not zero");
	chk_level_zero: assert property (s_gate_rd |-> prdata[4] == 1'b0 && prdata[0] == 1'b0)
		else $error("start level bits not zero");
	chk_gate_sel: assert property (s_gate_rd |-> prdata[1] == gate_q[1] && prdata[5] == gate_q[5])
		else $error("trigger select bits lost");
	chk_reload_back: assert property (rd && apb_req.paddr == RELOAD_BASE && rlv_q |-> prdata[15:0] == rl0_q)
		else $error("reload value not returned");
	chk_high_width: assert property (s_high_end |-> cnt_q == {8'h00, hl_q} + 16'h0001)
		else $error("high phase length wrong");
	chk_enable_stop: assert property ((!start_q[0] && !gate_q[1] && !ctl0_q[8] && clk_en)[*3] |-> !pulse_out[0])
		else $error("channel runs without start bit");
	chk_tg_stop: assert property ((ctl0_q[8] && !tg_q[0] && clk_en)[*3] |-> !pulse_out[0])
		else $error("channel runs without timing start");
	chk_gate_stop: assert property ((gate_q[1] && !ctl0_q[8] && !gate_in[0] && clk_en)[*5] |-> pulse_out[1:0] == 2'h0)
		else $error("pair runs without gate");
endmodule : pulse_width_reload_and_start_gate_properties

bind pulse_width_reload_and_start_gate pulse_width_reload_and_start_gate_properties u_chk (
	.clk(clk), .clk_en(clk_en), .reset_n(reset_n), .apb_req(apb_req), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .gate_in(gate_in), .pulse_out(pulse_out)
);

`default_nettype wire

//--- tb.sv
// Purpose: Self-checking bench for the pulse reload and start gate
// Assumes: Zero wait state slave, but waits are bounded, not assumed
// Notes:   Phase lengths measured in clk cycles after settling
`timescale 1ns/1ps
`default_nettype none

module tb
	import pulse_gen_pkg::*;
;
	logic        clk, clk_en, reset_n, pready, pslverr, slow, e;
	apb_req_t    req;
	logic [31:0] prdata, r;
	logic [1:0]  gate_req, gate_in;
	logic [3:0]  pulse_out;
	int          bad_count, checks_done, n;

	pulse_width_reload_and_start_gate DUT (.clk(clk), .clk_en(clk_en), .reset_n(reset_n),
		.apb_req(req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.gate_in(gate_in), .pulse_out(pulse_out));
	pulse_gate_source u_gate (.clk(clk), .reset_n(reset_n), .slow(slow),
		.gate_req(gate_req), .gate_in(gate_in));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		checks_done++;
		if (s !== x) begin
			bad_count++;
			$display("FAIL %0t seen %h want %h", $time, s, x);
		end
	endtask : chk

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : end_sim

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		req.penable <= 1'b1;
		// No wait count assumed; only the watchdog ends a stall
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(r, x);
	endtask : rd

	task automatic wl(input int c, input logic v, output int m);
		m = 0;
		while (pulse_out[c] !== v && m < 3000) begin
			@(posedge clk);
			#1;
			m++;
		end
	endtask : wl

	task automatic meas(input int c, input int xh, input int xl);
		int m;
		wl(c, 1'b0, m);
		wl(c, 1'b1, m);
		wl(c, 1'b0, m);
		chk(m, xh);
		wl(c, 1'b1, m);
		chk(m, xl);
	endtask : meas

	task automatic stop_chk(input int cyc);
		repeat (cyc) @(posedge clk);
		#1;
		chk(32'(pulse_out), 32'h0);
	endtask : stop_chk

	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		end_sim();
	end

	initial begin
		req = '0;
		clk_en = 1'b1;
		reset_n = 1'b0;
		slow = 1'b0;
		gate_req = 2'h0;
		bad_count = 0;
		checks_done = 0;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 4; i++) wr(RELOAD_BASE + 12'(4 * i), 32'(16'ha55a + i));
		for (int i = 0; i < 4; i++) rd(RELOAD_BASE + 12'(4 * i), 32'(16'ha55a + i));
		rd(12'h040, 32'h0);
		chk(32'(e), 32'h1);
		wr(GATE_OFS, 32'hff);
		rd(GATE_OFS, 32'h22);
		wr(GATE_OFS, 32'h0);
		// Plain 8-bit pair, each channel on its own bytes
		wr(RELOAD_BASE, 32'h0201);
		wr(RELOAD_BASE + 12'h4, 32'h0103);
		wr(START_OFS, 32'h3);
		meas(0, 3, 2);
		meas(1, 2, 4);
		// Wait for low; the reload lands in the high phase that follows, and the next low and high use the new widths
		wl(0, 1'b0, n);
		wr(RELOAD_BASE, 32'h0409);
		meas(0, 5, 10);
		wr(START_OFS, 32'h0);
		stop_chk(3);
		wr(CTRL_BASE, 32'h0400);
		wr(RELOAD_BASE, 32'h0102);
		wr(RELOAD_BASE + 12'h4, 32'h0100);
		wr(START_OFS, 32'h1);
		meas(0, 259, 257);
		chk(32'(pulse_out[1]), 32'h0);
		wr(START_OFS, 32'h0);
		wr(CTRL_BASE, 32'h0200);
		wr(RELOAD_BASE, 32'h0201);
		wr(RELOAD_BASE + 12'h4, 32'h0101);
		wr(START_OFS, 32'h3);
		meas(0, 6, 4);
		chk(32'(pulse_out[1]), 32'h0);
		wr(START_OFS, 32'h0);
		wr(CTRL_BASE, 32'h0600);
		wr(CTRL_BASE + 12'h4, 32'h0600);
		wr(RELOAD_BASE, 32'h0001);
		wr(RELOAD_BASE + 12'h4, 32'h0002);
		wr(RELOAD_BASE + 12'h8, 32'h0001);
		wr(RELOAD_BASE + 12'hc, 32'h0001);
		wr(START_OFS, 32'h1);
		meas(0, 4, 6);
		chk(32'(pulse_out[3:1]), 32'h0);
		wr(START_OFS, 32'h0);
		wr(CTRL_BASE, 32'h0);
		wr(CTRL_BASE + 12'h4, 32'h0);
		wr(RELOAD_BASE, 32'h0201);
		wr(RELOAD_BASE + 12'h8, 32'h0201);
		// Gate selected: start bits alone must not start the pairs
		wr(GATE_OFS, 32'h22);
		wr(START_OFS, 32'h5);
		stop_chk(10);
		gate_req <= 2'h1;
		meas(0, 3, 2);
		chk(32'(pulse_out[2]), 32'h0);
		slow <= 1'b1;
		gate_req <= 2'h2;
		meas(2, 3, 2);
		gate_req <= 2'h0;
		stop_chk(6);
		wr(GATE_OFS, 32'h0);
		wr(START_OFS, 32'h0);
		wr(CTRL_BASE, 32'h0100);
		wr(TG_OFS, 32'h1);
		meas(0, 3, 2);
		wr(TG_OFS, 32'h0);
		stop_chk(3);
		rd(CTRL_BASE, 32'h4100);
		wr(CTRL_BASE, 32'h0100);
		rd(CTRL_BASE, 32'h0100);
		wr(TG_OFS, 32'h1);
		wl(0, 1'b1, n);
		@(posedge clk);
		reset_n <= 1'b0;
		stop_chk(1);
		@(posedge clk);
		reset_n <= 1'b1;
		end_sim();
	end
endmodule : tb

`default_nettype wire
